// file: core/irq_unit_pkg.sv
package irq_unit_pkg;

  // special function register offsets (byte index on the register port)
  localparam logic [7:0] ENABLE_LOW_OFS    = 8'h00;
  localparam logic [7:0] ENABLE_SERIAL_OFS = 8'h01;
  localparam logic [7:0] FLAG_SYSTEM_OFS   = 8'h02;
  localparam logic [7:0] FLAG_SERIAL_OFS   = 8'h03;
  localparam logic [7:0] STATUS_OFS        = 8'h04;

  // enable register 1 fields
  localparam int EN_FLASH_VIOL_BIT = 5;
  localparam int EN_PIN_NMI_BIT    = 4;
  localparam int EN_OSC_FAULT_BIT  = 1;
  localparam int EN_WDT_BIT        = 0;
  localparam logic [7:0] ENABLE_LOW_MASK    = 8'h33;
  localparam logic [7:0] ENABLE_SERIAL_MASK = 8'h0f;

  // flag register 1 fields
  localparam int FL_PIN_NMI_BIT   = 4;
  localparam int FL_PIN_RESET_BIT = 3;
  localparam int FL_POWER_ON_BIT  = 2;
  localparam int FL_OSC_FAULT_BIT = 1;
  localparam int FL_WATCHDOG_BIT  = 0;
  localparam logic [7:0] FLAG_SYSTEM_MASK = 8'h1f;
  localparam logic [7:0] FLAG_SERIAL_MASK = 8'h0f;

  // serial fields (enable and flag registers 2 share the layout)
  localparam int SER_B_TX_BIT = 3;
  localparam int SER_B_RX_BIT = 2;
  localparam int SER_A_TX_BIT = 1;
  localparam int SER_A_RX_BIT = 0;

  // reset values: plain ones on every power-up clear, parenthesised on power-on only
  localparam logic [7:0] ENABLE_RST       = 8'h00;
  localparam logic [7:0] FLAG_SYS_PUC_SET = 8'h02;
  localparam logic [7:0] FLAG_SYS_POR_RST = 8'h06;
  localparam logic [7:0] FLAG_SERIAL_RST  = 8'h0a;

  // vector table
  localparam logic [15:0] VEC_TABLE_LOW  = 16'hffc0;
  localparam logic [15:0] VEC_RESET      = 16'hfffe;
  localparam logic [15:0] VEC_NMI        = 16'hfffc;
  localparam logic [15:0] VEC_T1_CH0     = 16'hfffa;
  localparam logic [15:0] VEC_T1_OTHER   = 16'hfff8;
  localparam logic [15:0] VEC_WATCHDOG   = 16'hfff4;
  localparam logic [15:0] VEC_T0_CH0     = 16'hfff2;
  localparam logic [15:0] VEC_T0_OTHER   = 16'hfff0;
  localparam logic [15:0] VEC_SERIAL_RX  = 16'hffee;
  localparam logic [15:0] VEC_SERIAL_TX  = 16'hffec;
  localparam logic [15:0] VEC_PORT2      = 16'hffe6;
  localparam logic [15:0] VEC_PORT1      = 16'hffe4;
  localparam logic [15:0] VEC_BOOT_KEY   = 16'hffde;
  localparam logic [15:0] ERASED_WORD    = 16'hffff;
  localparam logic [15:0] BOOT_KEY_OFF   = 16'haa55;
  localparam logic [15:0] BOOT_KEY_NOERS = 16'h0000;

  localparam logic [4:0] PRI_RESET    = 5'd31;
  localparam logic [4:0] PRI_NMI      = 5'd30;
  localparam logic [4:0] PRI_T1_CH0   = 5'd29;
  localparam logic [4:0] PRI_T1_OTHER = 5'd28;
  localparam logic [4:0] PRI_WATCHDOG = 5'd26;
  localparam logic [4:0] PRI_T0_CH0   = 5'd25;
  localparam logic [4:0] PRI_T0_OTHER = 5'd24;
  localparam logic [4:0] PRI_SER_RX   = 5'd23;
  localparam logic [4:0] PRI_SER_TX   = 5'd22;
  localparam logic [4:0] PRI_PORT2    = 5'd19;
  localparam logic [4:0] PRI_PORT1    = 5'd18;

  // fetch address checks
  localparam logic [15:0] PERIPH_TOP = 16'h01ff;

  // serial unit b mode
  typedef enum logic [1:0] {
    SER_MODE_UART = 2'b00,
    SER_MODE_SPI  = 2'b01,
    SER_MODE_I2C  = 2'b10
  } ser_mode_t;

  // boot state
  typedef enum logic [1:0] {
    BOOT_IDLE  = 2'b00,
    BOOT_FETCH = 2'b01,
    BOOT_RUN   = 2'b10,
    BOOT_SLEEP = 2'b11
  } boot_state_t;

  // peripheral flag sources, all on clk_i
  typedef struct packed {
    logic [2:0] t1_ccr;
    logic       t1_ovf;
    logic [2:0] t0_ccr;
    logic       t0_ovf;
    logic       wdt_interval;
    logic [7:0] port1;
    logic [7:0] port2;
    logic       ser_a_rx;
    logic       ser_a_tx;
    logic       ser_b_rx;
    logic       ser_b_tx;
    logic       arb_lost;
    logic       no_ack;
    logic       start_cond;
    logic       stop_cond;
  } periph_flags_t;

  // vector answer to the cpu
  typedef struct packed {
    logic        valid;
    logic [4:0]  priority_level;
    logic [15:0] vector_addr;
  } vector_req_t;

endpackage

// file: core/vectored_interrupt_sfr_unit.sv
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module vectored_interrupt_sfr_unit
  import irq_unit_pkg::*;
(
  // clock and power-on reset
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  // system reset and nmi inputs, synchronous to clk_i
  input  wire logic          pin_reset_i,
  input  wire logic          pin_nmi_i,
  input  wire logic          wdt_expire_i,
  input  wire logic          wdt_interval_mode_i,
  input  wire logic          flash_key_violation_i,
  input  wire logic          osc_fault_i,
  input  wire logic          flash_access_violation_i,
  // cpu side
  input  wire logic          global_irq_enable_i,
  input  wire logic          fetch_valid_i,
  input  wire logic [15:0]   fetch_addr_i,
  input  wire logic          fetch_unused_i,
  input  wire logic [15:0]   reset_vector_word_i,
  input  wire logic [15:0]   boot_key_word_i,
  input  wire logic          vector_ack_i,
  // peripheral sources
  input  wire periph_flags_t periph_flags_i,
  input  wire ser_mode_t     ser_b_mode_i,
  // register port
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic [7:0]         reg_rdata_o,
  // outputs
  output vector_req_t        vector_req_o,
  output logic               power_up_clear_o,
  output logic               deepest_sleep_mode_o,
  output logic               bootloader_disable_o,
  output logic               erase_on_bad_password_o
);

  logic [7:0]  en_low_q;
  logic [7:0]  en_ser_q;
  logic [7:0]  fl_sys_q;
  logic [7:0]  fl_ser_q;
  logic        puc_d;
  logic        puc_q;
  logic        pin_rst_q;
  logic        bad_fetch;
  logic        wr_en_low;
  logic        wr_en_ser;
  logic        wr_fl_sys;
  logic        wr_fl_ser;
  logic [7:0]  fl_sys_set;
  logic [7:0]  fl_ser_set;
  logic        rx_req;
  logic        tx_req;
  logic        nmi_req;
  vector_req_t vec_d;
  boot_state_t boot_q;

  assign wr_en_low = reg_wr_i && (reg_addr_i == ENABLE_LOW_OFS);
  assign wr_en_ser = reg_wr_i && (reg_addr_i == ENABLE_SERIAL_OFS);
  assign wr_fl_sys = reg_wr_i && (reg_addr_i == FLAG_SYSTEM_OFS);
  assign wr_fl_ser = reg_wr_i && (reg_addr_i == FLAG_SERIAL_OFS);

  // executing from the register window or holes is treated as a crash
  assign bad_fetch = fetch_valid_i &&
                     ((fetch_addr_i <= PERIPH_TOP) || fetch_unused_i);

  // every reset source folds into one power-up clear pulse
  assign puc_d = pin_reset_i || wdt_expire_i || flash_key_violation_i ||
                 bad_fetch;

  always_ff @(posedge clk_i) begin
    // remember a pin-caused clear: only that one wipes the watchdog flag
    if (sys_rst_i) begin
      puc_q     <= 1'b1;
      pin_rst_q <= 1'b0;
    end else begin
      puc_q     <= puc_d;
      pin_rst_q <= pin_reset_i;
    end
  end

  assign fl_sys_set = {3'b000,
                       pin_nmi_i,
                       pin_reset_i,
                       1'b0,
                       osc_fault_i,
                       (wdt_expire_i && !wdt_interval_mode_i) || flash_key_violation_i};

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fl_sys_q <= FLAG_SYS_POR_RST;
    end else if (puc_q) begin
      // pin reset flag survives a plain power-up clear, watchdog flag one not caused by the pin
      fl_sys_q[FL_PIN_NMI_BIT]   <= fl_sys_set[FL_PIN_NMI_BIT];
      fl_sys_q[FL_OSC_FAULT_BIT] <= FLAG_SYS_PUC_SET[FL_OSC_FAULT_BIT];
      fl_sys_q[FL_PIN_RESET_BIT] <= fl_sys_q[FL_PIN_RESET_BIT] ||
                                    fl_sys_set[FL_PIN_RESET_BIT];
      fl_sys_q[FL_WATCHDOG_BIT]  <= pin_rst_q ? 1'b0 :
                                    (fl_sys_q[FL_WATCHDOG_BIT] ||
                                     fl_sys_set[FL_WATCHDOG_BIT]);
    end else if (wr_fl_sys) begin
      fl_sys_q <= (reg_wdata_i | fl_sys_set) & FLAG_SYSTEM_MASK;
    end else begin
      fl_sys_q <= fl_sys_q | fl_sys_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || puc_q) begin
      en_low_q <= ENABLE_RST;
    end else if (wr_en_low) begin
      en_low_q <= reg_wdata_i & ENABLE_LOW_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || puc_q) begin
      en_ser_q <= ENABLE_RST;
    end else if (wr_en_ser) begin
      en_ser_q <= reg_wdata_i & ENABLE_SERIAL_MASK;
    end
  end

  // in i2c mode unit b's plain rx/tx come from its data flags
  assign fl_ser_set = {4'h0,
                       periph_flags_i.ser_b_tx,
                       periph_flags_i.ser_b_rx,
                       periph_flags_i.ser_a_tx,
                       periph_flags_i.ser_a_rx};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || puc_q) begin
      fl_ser_q <= FLAG_SERIAL_RST | fl_ser_set;
    end else if (wr_fl_ser) begin
      fl_ser_q <= (reg_wdata_i | fl_ser_set) & FLAG_SERIAL_MASK;
    end else begin
      fl_ser_q <= fl_ser_q | fl_ser_set;
    end
  end

  // read port: one-cycle latency, unmapped and absent bits read zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ENABLE_LOW_OFS) begin
        reg_rdata_o <= en_low_q;
      end else if (reg_addr_i == ENABLE_SERIAL_OFS) begin
        reg_rdata_o <= en_ser_q;
      end else if (reg_addr_i == FLAG_SYSTEM_OFS) begin
        reg_rdata_o <= fl_sys_q;
      end else if (reg_addr_i == FLAG_SERIAL_OFS) begin
        reg_rdata_o <= fl_ser_q;
      end else if (reg_addr_i == STATUS_OFS) begin
        reg_rdata_o <= {4'h0, boot_q, vector_req_o.valid, puc_q};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // nmi group: own enables only, global enable ignored
  assign nmi_req = (fl_sys_q[FL_PIN_NMI_BIT] && en_low_q[EN_PIN_NMI_BIT]) ||
                   (fl_sys_q[FL_OSC_FAULT_BIT] && en_low_q[EN_OSC_FAULT_BIT]) ||
                   (flash_access_violation_i && en_low_q[EN_FLASH_VIOL_BIT]);

  // unit b: i2c status goes to rx, data flags to tx; else plain flags
  assign rx_req = (fl_ser_q[SER_A_RX_BIT] && en_ser_q[SER_A_RX_BIT]) ||
                  (en_ser_q[SER_B_RX_BIT] &&
                   ((ser_b_mode_i == SER_MODE_I2C) ?
                    (periph_flags_i.arb_lost || periph_flags_i.no_ack ||
                     periph_flags_i.start_cond || periph_flags_i.stop_cond) :
                    fl_ser_q[SER_B_RX_BIT]));
  assign tx_req = (fl_ser_q[SER_A_TX_BIT] && en_ser_q[SER_A_TX_BIT]) ||
                  (en_ser_q[SER_B_TX_BIT] &&
                   ((ser_b_mode_i == SER_MODE_I2C) ?
                    (fl_ser_q[SER_B_TX_BIT] || fl_ser_q[SER_B_RX_BIT]) :
                    fl_ser_q[SER_B_TX_BIT]));

  // fixed-priority pick; nothing below ffe4 is ever produced
  always_comb begin
    vec_d = '0;
    if (puc_q) begin
      vec_d = '{1'b1, PRI_RESET, VEC_RESET};
    end else if (nmi_req) begin
      vec_d = '{1'b1, PRI_NMI, VEC_NMI};
    end else if (global_irq_enable_i) begin
      if (periph_flags_i.t1_ccr[0]) begin
        vec_d = '{1'b1, PRI_T1_CH0, VEC_T1_CH0};
      end else if (|{periph_flags_i.t1_ccr[2:1], periph_flags_i.t1_ovf}) begin
        vec_d = '{1'b1, PRI_T1_OTHER, VEC_T1_OTHER};
      end else if (periph_flags_i.wdt_interval && wdt_interval_mode_i &&
                   en_low_q[EN_WDT_BIT]) begin
        vec_d = '{1'b1, PRI_WATCHDOG, VEC_WATCHDOG};
      end else if (periph_flags_i.t0_ccr[0]) begin
        vec_d = '{1'b1, PRI_T0_CH0, VEC_T0_CH0};
      end else if (|{periph_flags_i.t0_ccr[2:1], periph_flags_i.t0_ovf}) begin
        vec_d = '{1'b1, PRI_T0_OTHER, VEC_T0_OTHER};
      end else if (rx_req) begin
        vec_d = '{1'b1, PRI_SER_RX, VEC_SERIAL_RX};
      end else if (tx_req) begin
        vec_d = '{1'b1, PRI_SER_TX, VEC_SERIAL_TX};
      end else if (|periph_flags_i.port2) begin
        vec_d = '{1'b1, PRI_PORT2, VEC_PORT2};
      end else if (|periph_flags_i.port1) begin
        vec_d = '{1'b1, PRI_PORT1, VEC_PORT1};
      end
    end
  end

  // registered so the cpu sees a stable vector for a whole cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      vector_req_o <= '0;
    end else if (vector_ack_i) begin
      vector_req_o <= '0;
    end else begin
      vector_req_o <= vec_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      power_up_clear_o <= 1'b1;
    end else begin
      power_up_clear_o <= puc_q;
    end
  end

  // after each clear, sample the reset vector word once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || puc_q) begin
      boot_q <= BOOT_FETCH;
    end else begin
      case (boot_q)
        BOOT_FETCH: begin
          boot_q <= (reset_vector_word_i == ERASED_WORD) ? BOOT_SLEEP : BOOT_RUN;
        end
        BOOT_SLEEP: begin
          boot_q <= BOOT_SLEEP;
        end
        default: begin
          boot_q <= BOOT_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      deepest_sleep_mode_o <= 1'b0;
    end else begin
      deepest_sleep_mode_o <= (boot_q == BOOT_SLEEP);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bootloader_disable_o    <= 1'b0;
      erase_on_bad_password_o <= 1'b1;
    end else begin
      bootloader_disable_o    <= (boot_key_word_i == BOOT_KEY_OFF);
      erase_on_bad_password_o <= (boot_key_word_i != BOOT_KEY_NOERS);
    end
  end

endmodule

// file: dv/irq_unit_props.sv
`timescale 1ns/100ps
module irq_unit_props
  import irq_unit_pkg::*;
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        wdt_interval_mode_i,
  input wire logic        global_irq_enable_i,
  input wire logic        fetch_valid_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic [15:0] reset_vector_word_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire vector_req_t vector_req_o,
  input wire logic        power_up_clear_o,
  input wire logic        deepest_sleep_mode_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  sequence s_clear;
    ##[1:4] power_up_clear_o;
  endsequence
  property p_en_low;
    s_rd(ENABLE_LOW_OFS) |=> (reg_rdata_o & ~ENABLE_LOW_MASK) == 8'h00;
  endproperty
  a_en_low: assert property (p_en_low) else $error("absent enable bit set");
  property p_flag_sys;
    s_rd(FLAG_SYSTEM_OFS) |=> (reg_rdata_o & ~FLAG_SYSTEM_MASK) == 8'h00;
  endproperty
  a_flag_sys: assert property (p_flag_sys) else $error("absent flag bit set");
  property p_serial;
    s_rd(ENABLE_SERIAL_OFS) or s_rd(FLAG_SERIAL_OFS) |=> reg_rdata_o[7:4] == 4'h0;
  endproperty
  a_serial: assert property (p_serial) else $error("absent serial bit set");
  property p_pri;
    vector_req_o.valid |-> vector_req_o.priority_level == vector_req_o.vector_addr[5:1]
      && vector_req_o.vector_addr[15:6] == 10'h3ff && !vector_req_o.vector_addr[0];
  endproperty
  a_pri: assert property (p_pri) else $error("vector and priority disagree");
  property p_bad_fetch;
    fetch_valid_i && fetch_addr_i <= PERIPH_TOP |-> s_clear;
  endproperty
  a_bad_fetch: assert property (p_bad_fetch) else $error("bad fetch without clear");
  property p_gie;
    vector_req_o.valid && vector_req_o.priority_level < PRI_NMI |-> $past(global_irq_enable_i);
  endproperty
  a_gie: assert property (p_gie) else $error("maskable vector while disabled");
  property p_wdt;
    vector_req_o.valid && vector_req_o.priority_level == PRI_WATCHDOG |-> $past(wdt_interval_mode_i);
  endproperty
  a_wdt: assert property (p_wdt) else $error("interval vector in watchdog mode");
  property p_sleep;
    $rose(deepest_sleep_mode_o) |-> $past(reset_vector_word_i, 2) == ERASED_WORD;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep with programmed vector");
endmodule

bind vectored_interrupt_sfr_unit irq_unit_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .wdt_interval_mode_i(wdt_interval_mode_i), .global_irq_enable_i(global_irq_enable_i),
  .fetch_valid_i(fetch_valid_i), .fetch_addr_i(fetch_addr_i),
  .reset_vector_word_i(reset_vector_word_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .vector_req_o(vector_req_o), .power_up_clear_o(power_up_clear_o),
  .deepest_sleep_mode_o(deepest_sleep_mode_o));

// file: dv/cpu_vector_partner.sv
`timescale 1ns/100ps
module cpu_vector_partner
  import irq_unit_pkg::*;
#(
  parameter int ACK_DELAY = 2
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // vector handshake
  input  wire vector_req_t vector_req_i,
  input  wire logic        slow_i,
  output logic             vector_ack_o
);
  localparam logic [3:0] FAST = 4'(ACK_DELAY);
  localparam logic [3:0] SLOW = 4'(3 * ACK_DELAY);
  logic [3:0] wait_q;
  // the core loads the handler word late, as a busy core would
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !vector_req_i.valid || vector_ack_o) begin
      wait_q       <= 4'h0;
      vector_ack_o <= 1'b0;
    end else begin
      wait_q       <= wait_q + 4'h1;
      vector_ack_o <= wait_q >= (slow_i ? SLOW : FAST);
    end
  end
endmodule

// file: dv/tb_vectored_interrupt_sfr_unit.sv
`timescale 1ns/100ps
module tb_vectored_interrupt_sfr_unit
  import irq_unit_pkg::*;
;
  logic          clk_i = 1'b0, sys_rst_i = 1'b1, pin_reset_i = 1'b0, pin_nmi_i = 1'b0;
  logic          wdt_expire_i = 1'b0, wdt_interval_mode_i = 1'b1, flash_key_violation_i = 1'b0;
  logic          osc_fault_i = 1'b0, flash_access_violation_i = 1'b0, fetch_valid_i = 1'b0;
  logic          global_irq_enable_i = 1'b0, fetch_unused_i = 1'b0, slow = 1'b0;
  logic          reg_wr_i = 1'b0, reg_rd_i = 1'b0, vector_ack_i;
  logic          power_up_clear_o, deepest_sleep_mode_o, bootloader_disable_o, erase_o;
  logic [15:0]   fetch_addr_i = 16'hc000, reset_vector_word_i = 16'hc000;
  logic [15:0]   boot_key_word_i = 16'h1234;
  logic [7:0]    reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic          rd_sh = 1'b0;
  logic [31:0]   seed = 32'hc31bcac1;
  periph_flags_t pf = '0;
  ser_mode_t     ser_b_mode_i = SER_MODE_UART;
  vector_req_t   vector_req_o;
  vector_req_t   exp_vec[$];
  logic [7:0]    exp_rd[$];
  int            bad_count = 0, comparisons = 0;
  logic [7:0]    nmi_en [3] = '{8'h10, 8'h02, 8'h20};
  logic [7:0]    rst_flags [5] = '{8'h0a, 8'h03, 8'h03, 8'h02, 8'h02};
  logic [20:0]   vexp [17] = '{{PRI_T1_CH0, VEC_T1_CH0}, {PRI_T1_OTHER, VEC_T1_OTHER},
    {PRI_T1_OTHER, VEC_T1_OTHER}, {PRI_WATCHDOG, VEC_WATCHDOG}, {PRI_T0_OTHER, VEC_T0_OTHER},
    {PRI_T0_OTHER, VEC_T0_OTHER}, {PRI_SER_RX, VEC_SERIAL_RX}, {PRI_SER_TX, VEC_SERIAL_TX},
    {PRI_PORT2, VEC_PORT2}, {PRI_PORT1, VEC_PORT1}, {PRI_SER_RX, VEC_SERIAL_RX},
    {PRI_SER_TX, VEC_SERIAL_TX}, {PRI_T0_CH0, VEC_T0_CH0}, {PRI_SER_RX, VEC_SERIAL_RX},
    {PRI_SER_RX, VEC_SERIAL_RX}, {PRI_SER_RX, VEC_SERIAL_RX}, {PRI_SER_RX, VEC_SERIAL_RX}};

  vectored_interrupt_sfr_unit uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .pin_reset_i(pin_reset_i), .pin_nmi_i(pin_nmi_i), .wdt_expire_i(wdt_expire_i),
    .wdt_interval_mode_i(wdt_interval_mode_i), .flash_key_violation_i(flash_key_violation_i),
    .osc_fault_i(osc_fault_i), .flash_access_violation_i(flash_access_violation_i),
    .global_irq_enable_i(global_irq_enable_i), .fetch_valid_i(fetch_valid_i),
    .fetch_addr_i(fetch_addr_i), .fetch_unused_i(fetch_unused_i),
    .reset_vector_word_i(reset_vector_word_i), .boot_key_word_i(boot_key_word_i),
    .vector_ack_i(vector_ack_i), .periph_flags_i(pf), .ser_b_mode_i(ser_b_mode_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .vector_req_o(vector_req_o),
    .power_up_clear_o(power_up_clear_o), .deepest_sleep_mode_o(deepest_sleep_mode_o),
    .bootloader_disable_o(bootloader_disable_o), .erase_on_bad_password_o(erase_o));
  cpu_vector_partner #(.ACK_DELAY(2)) cpu (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .vector_req_i(vector_req_o), .slow_i(slow), .vector_ack_o(vector_ack_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // outputs are sampled mid-cycle so the edge's own updates have landed
  always @(negedge clk_i) begin
    // read data stands only in the cycle after the strobe
    if (rd_sh && exp_rd.size() != 0) begin
      check("read data", {24'h0, reg_rdata_o}, {24'h0, exp_rd.pop_front()});
    end
    rd_sh <= reg_rd_i;
    if (vector_req_o.valid === 1'b1 && exp_vec.size() != 0) begin
      check("vector", {10'h0, vector_req_o}, {10'h0, exp_vec.pop_front()});
    end
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic exp_v(input logic [20:0] pa);
    exp_vec.push_back({1'b1, pa});
  endtask
  task automatic wait_vec();
    int n;
    n = 0;
    while (exp_vec.size() != 0 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    check("vector pending", exp_vec.size(), 0);
    exp_vec.delete();
  endtask
  task automatic set_src(input int k, input logic v);
    seed = xs(seed);
    @(posedge clk_i);
    slow <= seed[2];
    if (k inside {10, 11, 13, 14, 15}) ser_b_mode_i <= SER_MODE_I2C;
    else if (k == 16) ser_b_mode_i <= SER_MODE_SPI;
    else ser_b_mode_i <= SER_MODE_UART;
    case (k)
      0: pf.t1_ccr[0] <= v;
      1: pf.t1_ccr[2] <= v;
      2: pf.t1_ovf <= v;
      3: pf.wdt_interval <= v;
      4: pf.t0_ccr[1] <= v;
      5: pf.t0_ovf <= v;
      6: pf.ser_a_rx <= v;
      7: pf.ser_b_tx <= v;
      8: pf.port2 <= v ? {seed[7:1], 1'b1} : 8'h00;
      9: pf.port1 <= v ? {seed[15:9], 1'b1} : 8'h00;
      10: pf.arb_lost <= v;
      12: pf.t0_ccr[0] <= v;
      13: pf.start_cond <= v;
      14: pf.no_ack <= v;
      15: pf.stop_cond <= v;
      default: pf.ser_b_rx <= v;
    endcase
  endtask
  task automatic hit(input int k, input logic v);
    @(posedge clk_i);
    case (k)
      0: pin_reset_i <= v;
      1: wdt_expire_i <= v;
      2: flash_key_violation_i <= v;
      3: begin
        fetch_valid_i <= v;
        fetch_addr_i  <= {7'h00, seed[8:0]};
      end
      4: begin
        fetch_valid_i  <= v;
        fetch_unused_i <= v;
        fetch_addr_i   <= 16'hc000;
      end
      5: pin_nmi_i <= v;
      6: osc_fault_i <= v;
      default: flash_access_violation_i <= v;
    endcase
  endtask
  task automatic por();
    sys_rst_i <= 1'b1;
    exp_v({PRI_RESET, VEC_RESET});
    idle(2);
    sys_rst_i <= 1'b0;
    wait_vec();
    idle(4);
    rd(FLAG_SYSTEM_OFS, FLAG_SYS_POR_RST);
    rd(FLAG_SERIAL_OFS, FLAG_SERIAL_RST);
    rd(STATUS_OFS, 8'h08);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    por();
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      wr(ENABLE_LOW_OFS, seed[7:0]);
      rd(ENABLE_LOW_OFS, seed[7:0] & ENABLE_LOW_MASK);
      wr(ENABLE_SERIAL_OFS, seed[15:8]);
      rd(ENABLE_SERIAL_OFS, seed[15:8] & ENABLE_SERIAL_MASK);
    end
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    $display("test registers done");
    wr(FLAG_SERIAL_OFS, 8'h00);
    wr(ENABLE_SERIAL_OFS, 8'h0f);
    wr(ENABLE_LOW_OFS, 8'h01);
    @(posedge clk_i);
    global_irq_enable_i <= 1'b1;
    for (int k = 0; k < 17; k++) begin
      exp_v(vexp[k]);
      set_src(k, 1'b1);
      wait_vec();
      set_src(k, 1'b0);
      wr(FLAG_SERIAL_OFS, 8'h00);
      idle(4);
    end
    global_irq_enable_i <= 1'b0;
    set_src(9, 1'b1);
    set_src(0, 1'b1);
    idle(4);
    check("masked vector", {31'h0, vector_req_o.valid}, 32'h0);
    exp_v({PRI_T1_CH0, VEC_T1_CH0});
    global_irq_enable_i <= 1'b1;
    wait_vec();
    set_src(9, 1'b0);
    set_src(0, 1'b0);
    idle(4);
    global_irq_enable_i <= 1'b0;
    $display("test vectors done");
    // global enable stays low: this group must still get through
    for (int k = 5; k < 8; k++) begin
      exp_v({PRI_NMI, VEC_NMI});
      wr(ENABLE_LOW_OFS, nmi_en[k-5]);
      hit(k, 1'b1);
      wait_vec();
      hit(k, 1'b0);
      wr(ENABLE_LOW_OFS, 8'h00);
      wr(FLAG_SYSTEM_OFS, 8'h00);
      idle(4);
    end
    $display("test nmi done");
    wdt_interval_mode_i <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      seed = xs(seed);
      wr(ENABLE_LOW_OFS, 8'h21);
      wr(FLAG_SYSTEM_OFS, 8'h00);
      exp_v({PRI_RESET, VEC_RESET});
      hit(k, 1'b1);
      hit(k, 1'b0);
      wait_vec();
      idle(4);
      rd(ENABLE_LOW_OFS, ENABLE_RST);
      rd(FLAG_SYSTEM_OFS, rst_flags[k]);
      rd(FLAG_SERIAL_OFS, FLAG_SERIAL_RST);
    end
    $display("test resets done");
    // key violation leaves the watchdog flag set; the pin reset below must wipe it
    hit(2, 1'b1);
    hit(2, 1'b0);
    idle(4);
    reset_vector_word_i <= ERASED_WORD;
    boot_key_word_i     <= BOOT_KEY_OFF;
    hit(0, 1'b1);
    hit(0, 1'b0);
    idle(8);
    check("sleep", {31'h0, deepest_sleep_mode_o}, 32'h1);
    check("loader off", {31'h0, bootloader_disable_o}, 32'h1);
    rd(FLAG_SYSTEM_OFS, 8'h0a);
    reset_vector_word_i <= 16'hc000;
    boot_key_word_i     <= BOOT_KEY_NOERS;
    hit(0, 1'b1);
    hit(0, 1'b0);
    idle(8);
    check("sleep", {31'h0, deepest_sleep_mode_o}, 32'h0);
    check("loader off", {31'h0, bootloader_disable_o}, 32'h0);
    check("erase", {31'h0, erase_o}, 32'h0);
    $display("test boot word done");
    por();
    $display("test power on done");
    tally_and_finish();
  end
endmodule
